//--- include/dmr_pkg.sv
// constants, types and helpers for the dram command and mode register block
// How it works
// R01: Two clocks between write end and read.
// R02: CKE held three sampled edges per level.
// R03: Bursts of four or eight, after Active.
// R04: Active takes bank, row; access takes column.
// R05: CKE and ODT low during power ramp.
// R06: Wait 200 us, then NOP, raise CKE.
// R07: 400 ns of NOPs, then precharge all.
// R08: Write extended registers two, then three.
// R09: Write extended register one, DLL enabled.
// R10: Mode write with A8 high resets DLL.
// R11: Precharge all, then two or more refreshes.
// R12: Mode write again with A8 low.
// R13: Calibration 200 clocks after DLL reset.
// R14: Skipped calibration: default then exit writes.
// R15: Every mode write resends all fields.
// R16: Mode writes never disturb stored array state.
// R17: Mode register undefined until first programmed.
// R18: Mode write: all strobes, bank bits low.
// R19: Mode write only idle, CKE high, spaced.
// R20: Decode burst length, order, CAS latency.
// R21: Test mode, DLL reset, write recovery fields.
// R22: Bit ten picks single-ended or differential strobe.
// R23: No read within 200 clocks of DLL reset.
// R24: Ready only after full initialization; the core raises ready 200 clocks after a DLL-reset mode write.
package dmr_pkg;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int MR_W = 16;
    localparam int AP_BIT = 10;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLL_BIT = 8;
    localparam int MR_WR_LSB = 9;
    localparam int MR_STROBE_BIT = 10;
    localparam logic [2:0] BL4_CODE = 3'h2;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [MR_W-1:0] MR_RESET = 16'h0000;
    localparam logic [1:0] CKE_MIN_CK = 2'h3;
    localparam logic [1:0] WTR_CK = 2'h2;
    localparam logic [1:0] MRD_CK = 2'h2;
    localparam logic [7:0] DLL_LOCK_CK = 8'hC8;

    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MODE} dmr_cmd_code_t;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [ROW_W-1:0] addr;
    } dmr_cmd_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic auto_pre;
        logic last;
    } dmr_acc_t;

    typedef struct packed {
        logic valid;
        logic bl8;
        logic interleave;
        logic [2:0] cas_lat;
        logic test_mode;
        logic dll_reset;
        logic [2:0] wr_rec;
        logic single_strobe;
    } dmr_mode_t;

    typedef struct packed {
        logic wtr;
        logic cke_hold;
        logic mode_set;
        logic early_read;
        logic no_mode;
        logic bank_closed;
    } dmr_err_t;

    function automatic dmr_cmd_code_t dmr_decode(input dmr_cmd_t c);
        if (c.cs_n) begin
            return CMD_NOP;
        end
        unique case ({c.ras_n, c.cas_n, c.we_n})
            3'h0: return CMD_MODE;
            3'h1: return CMD_REF;
            3'h2: return CMD_PRE;
            3'h3: return CMD_ACT;
            3'h4: return CMD_WR;
            3'h5: return CMD_RD;
            3'h6: return CMD_NOP;
            3'h7: return CMD_NOP;
        endcase
    endfunction

    // field split of the operating mode register
    function automatic dmr_mode_t dmr_mode_decode(input logic [MR_W-1:0] w, input logic v);
        dmr_mode_t m;
        m.valid = v;
        m.bl8 = (w[MR_BL_LSB+:3] == BL8_CODE); // R20
        m.interleave = w[MR_BT_BIT]; // R20
        m.cas_lat = w[MR_CL_LSB+:3]; // R20
        m.test_mode = w[MR_TM_BIT]; // R21
        m.dll_reset = w[MR_DLL_BIT]; // R21
        m.wr_rec = w[MR_WR_LSB+:3]; // R21
        m.single_strobe = w[MR_STROBE_BIT]; // R22
        return m;
    endfunction
endpackage

//--- hw/dmr_sync.sv
// toggle crossing of the mode register word into the system clock
module dmr_sync (
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_en,
    input wire logic load,
    input wire logic [dmr_pkg::MR_W-1:0] din,
    input wire logic dst_clk,
    input wire logic dst_rst,
    input wire logic dst_en,
    output logic [dmr_pkg::MR_W-1:0] dout,
    output logic dvalid
);
    import dmr_pkg::*;

    typedef struct packed {
        logic [MR_W-1:0] data;
        logic tog;
    } dmr_src_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic seen;
        logic [MR_W-1:0] data;
        logic valid;
    } dmr_dst_t;

    dmr_src_t sq, next_sq;
    dmr_dst_t dq, next_dq;

    always_comb begin
        next_sq = sq;
        if (src_rst) begin
            next_sq = '0;
        end else if (src_en && load) begin
            next_sq.data = din;
            next_sq.tog = ~sq.tog;
        end
    end

    always_ff @(posedge src_clk) begin
        sq <= next_sq;
    end

    always_comb begin
        next_dq = dq;
        if (dst_rst) begin
            next_dq = '0;
        end else if (dst_en) begin
            next_dq.s1 = sq.tog;
            next_dq.s2 = dq.s1;
            next_dq.seen = dq.s2;
            if (dq.s2 != dq.seen) begin
                next_dq.data = sq.data;
                next_dq.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge dst_clk) begin
        dq <= next_dq;
    end

    assign dout = dq.data;
    assign dvalid = dq.valid;
endmodule // dmr_sync

//--- hw/dmr_core.sv
// command decoder, bank tracker, burst sequencer and mode register of the dram
module dmr_core (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic link_ck,
    input dmr_pkg::dmr_cmd_t cmd_in,
    output dmr_pkg::dmr_acc_t acc,
    output dmr_pkg::dmr_mode_t mode,
    output dmr_pkg::dmr_err_t err,
    output logic ready
);
    import dmr_pkg::*;

    localparam int ERR_W = $bits(dmr_err_t);

    typedef struct packed {
        logic [1:0] rst_s;
        logic [1:0] ce_s;
        logic cke_q;
        logic [1:0] cke_cnt;
        logic [MR_W-1:0] mr;
        logic mr_valid;
        logic mr_upd;
        logic dll_seen;
        logic [7:0] dll_cnt;
        logic [1:0] mrd_cnt;
        logic [1:0] wtr_cnt;
        logic [3:0] open;
        logic [3:0][ROW_W-1:0] row;
        logic busy;
        logic bwrite;
        logic bauto;
        logic [1:0] bbank;
        logic [COL_W-1:0] bcol;
        logic [2:0] beat;
        logic ready;
        dmr_acc_t acc;
        dmr_err_t err;
    } dmr_lnk_t;

    typedef struct packed {
        logic [ERR_W:0] st1;
        logic [ERR_W:0] st2;
        dmr_mode_t mode;
    } dmr_sys_t;

    // ****************************************
    // link side
    // ****************************************
    dmr_lnk_t q, next_q;
    dmr_cmd_code_t cmd;
    logic lrst;
    logic lce;
    logic take;
    logic start;
    logic bl8;
    logic [2:0] last_beat;

    // column of one beat in the programmed order
    function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] s, input logic [2:0] i,
                                                  input logic b8, input logic il);
        logic [2:0] lo;
        lo = il ? (s[2:0] ^ i) : (s[2:0] + i);
        return b8 ? {s[COL_W-1:3], lo} : {s[COL_W-1:2], lo[1:0]};
    endfunction

    assign lrst = q.rst_s[1];
    assign lce = q.ce_s[1];
    assign cmd = dmr_decode(cmd_in);
    assign take = cmd_in.cke && q.cke_q;
    assign bl8 = (q.mr[MR_BL_LSB+:3] == BL8_CODE);
    assign last_beat = bl8 ? 3'h7 : 3'h3;
    assign start = take && (cmd == CMD_RD || cmd == CMD_WR) && q.mr_valid && q.open[cmd_in.ba];

    always_comb begin
        next_q = q;
        next_q.rst_s = {q.rst_s[0], rst};
        next_q.ce_s = {q.ce_s[0], ce};
        if (lrst) begin
            next_q = '0;
            next_q.mr = MR_RESET;
            next_q.cke_cnt = CKE_MIN_CK;
            next_q.rst_s = {q.rst_s[0], rst};
            next_q.ce_s = {q.ce_s[0], ce};
        end else if (lce) begin
            next_q.acc.valid = 1'b0;
            next_q.acc.last = 1'b0;
            next_q.mr_upd = 1'b0;
            // clock enable registration
            next_q.cke_q = cmd_in.cke;
            if (cmd_in.cke != q.cke_q) begin
                next_q.cke_cnt = 2'h1;
                if (q.cke_cnt < CKE_MIN_CK) begin
                    next_q.err.cke_hold = 1'b1; // R02
                end
            end else if (q.cke_cnt != CKE_MIN_CK) begin
                next_q.cke_cnt = q.cke_cnt + 2'h1;
            end
            if (q.mrd_cnt != 2'h0) begin
                next_q.mrd_cnt = q.mrd_cnt - 2'h1;
            end
            if (q.wtr_cnt != 2'h0) begin
                next_q.wtr_cnt = q.wtr_cnt - 2'h1;
            end
            if (q.dll_cnt != 8'h00) begin
                next_q.dll_cnt = q.dll_cnt - 8'h01;
            end
            // burst beats
            if (q.busy) begin
                next_q.acc.valid = 1'b1;
                next_q.acc.col = beat_col(q.bcol, q.beat, bl8, q.mr[MR_BT_BIT]); // R03
                next_q.beat = q.beat + 3'h1;
                if (q.beat == last_beat) begin
                    next_q.busy = 1'b0;
                    next_q.acc.last = 1'b1;
                    if (q.bwrite) begin
                        next_q.wtr_cnt = WTR_CK; // R01
                    end
                    if (q.bauto) begin
                        next_q.open[q.bbank] = 1'b0;
                    end
                end
            end
            // commands
            if (take) begin
                if (q.mrd_cnt != 2'h0 && cmd != CMD_NOP) begin
                    next_q.err.mode_set = 1'b1; // R19
                end
                unique case (cmd)
                    CMD_NOP, CMD_REF: begin
                    end
                    CMD_ACT: begin
                        next_q.open[cmd_in.ba] = 1'b1; // R04
                        next_q.row[cmd_in.ba] = cmd_in.addr; // R04
                    end
                    CMD_RD, CMD_WR: begin
                        if (!q.mr_valid) begin
                            next_q.err.no_mode = 1'b1; // R17
                        end else if (!q.open[cmd_in.ba]) begin
                            next_q.err.bank_closed = 1'b1; // R03
                        end
                        if (cmd == CMD_RD && q.dll_cnt != 8'h00) begin
                            next_q.err.early_read = 1'b1; // R23
                        end
                        if (cmd == CMD_RD && (q.wtr_cnt != 2'h0 || (q.busy && q.bwrite))) begin
                            next_q.err.wtr = 1'b1; // R01
                        end
                        if (start) begin
                            next_q.busy = 1'b1;
                            next_q.beat = 3'h1;
                            next_q.bwrite = (cmd == CMD_WR);
                            next_q.bbank = cmd_in.ba;
                            next_q.bcol = cmd_in.addr[COL_W-1:0]; // R04
                            next_q.bauto = cmd_in.addr[AP_BIT]; // R04
                            next_q.acc.valid = 1'b1;
                            next_q.acc.last = 1'b0;
                            next_q.acc.write = (cmd == CMD_WR);
                            next_q.acc.bank = cmd_in.ba;
                            next_q.acc.row = q.row[cmd_in.ba];
                            next_q.acc.col = beat_col(cmd_in.addr[COL_W-1:0], 3'h0, bl8, q.mr[MR_BT_BIT]);
                            next_q.acc.auto_pre = cmd_in.addr[AP_BIT];
                        end
                    end
                    CMD_PRE: begin
                        if (cmd_in.addr[AP_BIT]) begin
                            next_q.open = 4'h0;
                        end else begin
                            next_q.open[cmd_in.ba] = 1'b0;
                        end
                    end
                    CMD_MODE: begin
                        // bank and row state left alone
                        next_q.mrd_cnt = MRD_CK - 2'h1; // R19
                        if (q.open != 4'h0 || q.busy) begin
                            next_q.err.mode_set = 1'b1; // R19
                        end
                        if (cmd_in.ba == 2'h0) begin
                            next_q.mr = {{(MR_W - ROW_W){1'b0}}, cmd_in.addr}; // R18 R15
                            next_q.mr_valid = 1'b1; // R17
                            next_q.mr_upd = 1'b1;
                            if (cmd_in.addr[MR_DLL_BIT]) begin
                                next_q.dll_cnt = DLL_LOCK_CK; // R10 R23
                                next_q.dll_seen = 1'b1; // R12
                            end
                        end
                    end
                endcase
            end
            next_q.ready = next_q.mr_valid && next_q.dll_seen && next_q.dll_cnt == 8'h00; // R24
        end
    end

    always_ff @(posedge link_ck) begin
        q <= next_q;
    end

    assign acc = q.acc;

    // ****************************************
    // system side
    // ****************************************
    dmr_sys_t s, next_s;
    logic [MR_W-1:0] mr_word;
    logic mr_seen;

    dmr_sync u_sync (
        .src_clk(link_ck),
        .src_rst(lrst),
        .src_en(lce),
        .load(q.mr_upd),
        .din(q.mr),
        .dst_clk(clock),
        .dst_rst(rst),
        .dst_en(ce),
        .dout(mr_word),
        .dvalid(mr_seen)
    );

    always_comb begin
        next_s = s;
        if (rst) begin
            next_s = '0;
        end else if (ce) begin
            next_s.st1 = {q.ready, q.err};
            next_s.st2 = s.st1;
            next_s.mode = dmr_mode_decode(mr_word, mr_seen); // R20 R21 R22
        end
    end

    always_ff @(posedge clock) begin
        s <= next_s;
    end

    assign mode = s.mode;
    assign err = s.st2[ERR_W-1:0];
    assign ready = s.st2[ERR_W];

    // ****************************************
    // checks
    // ****************************************
    AST_CKE_HOLD: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R02
        (cmd_in.cke != q.cke_q && q.cke_cnt < CKE_MIN_CK) |=> q.err.cke_hold)
        else $error("short clock enable level not flagged");
    AST_WTR: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R01
        (take && cmd == CMD_RD && q.wtr_cnt != 2'h0) |=> q.err.wtr)
        else $error("read too soon after write not flagged");
    AST_BURST4: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R03
        (start && !bl8) ##1 (!start)[*3] |=> (acc.valid && acc.last))
        else $error("four beat burst did not end on fourth beat");
    AST_BURST8: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R03
        (start && bl8) ##1 (!start && acc.valid && !acc.last)[*7] |=> acc.last)
        else $error("eight beat burst did not end on eighth beat");
    AST_ROW: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R04
        (take && cmd == CMD_ACT) |=> (q.open[$past(cmd_in.ba)] && q.row[$past(cmd_in.ba)] == $past(cmd_in.addr)))
        else $error("active did not capture bank and row");
    AST_MODE_CAPT: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R18
        (take && cmd == CMD_MODE && cmd_in.ba == 2'h0) |=> (q.mr[ROW_W-1:0] == $past(cmd_in.addr) && q.mr_valid))
        else $error("mode write not captured");
    AST_NO_MODE: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R17
        (take && cmd == CMD_RD && !q.mr_valid) |=> (q.err.no_mode && !q.busy))
        else $error("access before programming accepted");
    AST_MODE_KEEP: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R16
        (take && cmd == CMD_MODE && !q.busy) |=> $stable(q.row) && $stable(q.open))
        else $error("mode write disturbed bank state");
    AST_DLL_WAIT: assert property (@(posedge link_ck) disable iff (lrst || !lce) // R23
        (take && cmd == CMD_MODE && cmd_in.ba == 2'h0 && cmd_in.addr[MR_DLL_BIT])
        |=> (q.dll_cnt == DLL_LOCK_CK && !q.ready) ##1 (!q.ready)[*8])
        else $error("ready raised during dll lock wait");
    AST_SYS_MODE: assert property (@(posedge clock) disable iff (rst || !ce) // R22
        mr_seen |=> mode.single_strobe == $past(mr_word[MR_STROBE_BIT]))
        else $error("strobe select not decoded");

    COV_READ: cover property (@(posedge link_ck) disable iff (lrst) start && cmd == CMD_RD);
    COV_WRITE8: cover property (@(posedge link_ck) disable iff (lrst) start && cmd == CMD_WR && bl8);
    COV_READY: cover property (@(posedge link_ck) disable iff (lrst) $rose(q.ready));
    COV_AUTOPRE: cover property (@(posedge link_ck) disable iff (lrst) acc.last && acc.auto_pre);
endmodule // dmr_core

//--- test/dmr_host.sv
// controller-side command model driving the dram command link
module dmr_host #(
    parameter int POWER_WAIT = 3125
) (
    output logic link_ck,
    output dmr_pkg::dmr_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    import dmr_pkg::*;

    initial begin
        link_ck = 1'b0;
        #13;
        forever #32 link_ck = ~link_ck;
    end

    initial cmd = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, addr: 13'h0000};

    // ****************************************
    // command tasks
    // ****************************************
    // one command edge, then deselect with scrambled address lines
    task automatic send(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a);
        @(posedge link_ck);
        cmd <= '{cke: 1'b1, cs_n: 1'b0, ras_n: op[2], cas_n: op[1], we_n: op[0], ba: ba, addr: a};
        @(posedge link_ck);
        cmd <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: ~ba, addr: ~a};
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge link_ck);
            cmd.ba <= ~cmd.ba;
            cmd.addr <= ~cmd.addr;
        end
    endtask

    task automatic cke_set(input logic v);
        @(posedge link_ck);
        cmd.cke <= v;
        cmd.cs_n <= 1'b1;
    endtask

    // power-up sequence, optionally with a premature read
    task automatic init_seq(input logic [12:0] mr, input logic early_rd);
        cke_set(1'b0);
        idle(POWER_WAIT);
        cke_set(1'b1);
        idle(7);
        send(3'h2, 2'h0, 13'h0400);
        send(3'h0, 2'h2, 13'h0000);
        send(3'h0, 2'h3, 13'h0000);
        send(3'h0, 2'h1, 13'h0000);
        send(3'h0, 2'h0, mr | 13'h0100);
        if (early_rd) begin
            send(3'h3, 2'h0, 13'h0000);
            send(3'h5, 2'h0, 13'h0000);
        end
        send(3'h2, 2'h0, 13'h0400);
        send(3'h1, 2'h0, 13'h0000);
        send(3'h1, 2'h0, 13'h0000);
        send(3'h0, 2'h0, mr & 13'h1EFF);
        idle(200);
        send(3'h0, 2'h1, 13'h0380);
        send(3'h0, 2'h1, 13'h0000);
    endtask
endmodule // dmr_host

//--- test/testbench.sv
// self-checking bench for the dram command and mode register block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dmr_pkg::*;
    localparam logic [12:0] MR_BL4 = 13'h0652;
    localparam logic [12:0] MR_BL8 = 13'h024B;
    logic clock;
    logic rst;
    logic ce;
    logic link_ck;
    dmr_cmd_t cmd_in;
    dmr_acc_t acc;
    dmr_mode_t mode;
    dmr_err_t err;
    logic ready;
    int n_fail;
    int checks;

    dmr_host u_dmr_host (.link_ck(link_ck), .cmd(cmd_in));
    dmr_core u_dmr_core (.clock(clock), .rst(rst), .ce(ce), .link_ck(link_ck), .cmd_in(cmd_in),
        .acc(acc), .mode(mode), .err(err), .ready(ready));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk_bits(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_acc(input dmr_acc_t got, input dmr_acc_t exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_mode(input logic [12:0] w);
        dmr_mode_t e;
        e = '{valid: 1'b1, bl8: (w[2:0] == BL8_CODE), interleave: w[3], cas_lat: w[6:4], test_mode: w[7],
            dll_reset: w[8], wr_rec: w[11:9], single_strobe: w[10]};
        chk_bits(32'(mode), 32'(e));
    endtask

    task automatic do_reset();
        u_dmr_host.cke_set(1'b0);
        u_dmr_host.idle(4);
        @(posedge clock);
        rst <= 1'b1;
        repeat (12) @(posedge clock);
        repeat (4) @(posedge link_ck);
        @(posedge clock);
        rst <= 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic burst(input logic w, input logic [1:0] b, input logic [12:0] r, input logic [8:0] s,
        input logic b8, input logic il, input logic ap);
        dmr_acc_t e;
        int n;
        n = b8 ? 8 : 4;
        u_dmr_host.send(3'h3, b, r);
        u_dmr_host.send(w ? 3'h4 : 3'h5, b, {2'h0, ap, 1'b0, s});
        for (int i = 0; i < n; i++) begin
            @(negedge link_ck);
            e = '{valid: 1'b1, write: w, bank: b, row: r, col: s, auto_pre: ap, last: (i == n - 1)};
            if (il) e.col = s ^ 9'(i);
            else if (b8) e.col[2:0] = s[2:0] + 3'(i);
            else e.col[1:0] = s[1:0] + 2'(i);
            chk_acc(acc, e);
        end
        @(negedge link_ck);
        chk_bits(32'(acc.valid), 32'h0);
    endtask

    task automatic t_no_mode();
        @(negedge link_ck);
        chk_bits(64'({acc, mode, err, ready}), 64'h0);
        u_dmr_host.cke_set(1'b1);
        u_dmr_host.idle(4);
        u_dmr_host.send(3'h3, 2'h0, 13'h0010);
        u_dmr_host.send(3'h5, 2'h0, 13'h0005);
        @(negedge link_ck);
        chk_bits(32'(acc.valid), 32'h0);
        repeat (8) @(posedge clock);
        chk_bits(32'({err, ready}), 32'h04);
    endtask

    task automatic t_init();
        int k;
        k = 0;
        fork
            u_dmr_host.init_seq(MR_BL4, 1'b0);
            begin
                while (mode.valid !== 1'b1 && k < 30000) begin
                    @(posedge clock);
                    k++;
                end
                chk_bits(32'(mode.valid), 32'h1);
                chk_bits(32'(ready), 32'h0);
            end
        join
        repeat (8) @(posedge clock);
        chk_bits(32'(ready), 32'h1);
        chk_mode(MR_BL4);
    endtask

    task automatic t_freeze();
        @(posedge clock);
        ce <= 1'b0;
        u_dmr_host.idle(3);
        u_dmr_host.send(3'h5, 2'h1, 13'h0003);
        u_dmr_host.send(3'h0, 2'h0, MR_BL8);
        @(negedge link_ck);
        chk_bits(32'(acc.valid), 32'h0);
        @(posedge clock);
        ce <= 1'b1;
        u_dmr_host.idle(4);
        repeat (6) @(posedge clock);
        chk_bits(32'(err), 32'h00);
        chk_mode(MR_BL4);
    endtask

    task automatic t_bursts();
        burst(1'b0, 2'h1, 13'h1ABC, 9'h005, 1'b0, 1'b0, 1'b0);
        burst(1'b1, 2'h2, 13'h0123, 9'h1FE, 1'b0, 1'b0, 1'b1);
        u_dmr_host.send(3'h2, 2'h0, 13'h0400);
        u_dmr_host.send(3'h0, 2'h0, MR_BL8);
        u_dmr_host.idle(2);
        repeat (6) @(posedge clock);
        chk_mode(MR_BL8);
        burst(1'b0, 2'h3, 13'h1FFF, 9'h00D, 1'b1, 1'b1, 1'b0);
        u_dmr_host.send(3'h2, 2'h0, 13'h0400);
        u_dmr_host.send(3'h0, 2'h0, MR_BL8 & 13'h1FF7);
        burst(1'b0, 2'h0, 13'h0000, 9'h006, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_turnaround();
        u_dmr_host.send(3'h2, 2'h0, 13'h0400);
        burst(1'b1, 2'h0, 13'h0040, 9'h010, 1'b1, 1'b0, 1'b0);
        u_dmr_host.idle(2);
        u_dmr_host.send(3'h5, 2'h0, 13'h0010);
        u_dmr_host.idle(10);
        repeat (6) @(posedge clock);
        chk_bits(32'(err), 32'h00);
        u_dmr_host.send(3'h4, 2'h0, 13'h0010);
        u_dmr_host.idle(6);
        u_dmr_host.send(3'h5, 2'h0, 13'h0010);
        u_dmr_host.idle(10);
        repeat (6) @(posedge clock);
        chk_bits(32'(err.wtr), 32'h1);
        u_dmr_host.send(3'h4, 2'h0, 13'h0010);
        u_dmr_host.send(3'h5, 2'h0, 13'h0010);
        u_dmr_host.idle(10);
        repeat (6) @(posedge clock);
        chk_bits(32'(err.wtr), 32'h1);
    endtask

    task automatic t_faults();
        u_dmr_host.init_seq(MR_BL4, 1'b1);
        u_dmr_host.cke_set(1'b0);
        u_dmr_host.cke_set(1'b1);
        u_dmr_host.idle(4);
        u_dmr_host.send(3'h5, 2'h2, 13'h0000);
        @(negedge link_ck);
        chk_bits(32'(acc.valid), 32'h0);
        u_dmr_host.send(3'h3, 2'h1, 13'h0001);
        u_dmr_host.send(3'h0, 2'h0, MR_BL4);
        u_dmr_host.idle(4);
        repeat (6) @(posedge clock);
        chk_bits(32'(err), 32'h1D);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        n_fail = 0;
        checks = 0;
        do_reset();
        t_no_mode();
        do_reset();
        t_init();
        t_freeze();
        t_bursts();
        t_turnaround();
        do_reset();
        t_faults();
        report_and_stop();
    end

    initial begin
        #600000;
        n_fail++;
        report_and_stop();
    end
endmodule // testbench
